// ---- core/osdpa_core.sv ----
// osd pixel processing and global attribute control
`timescale 1ns/100ps
`default_nettype none
`include "osdpa_map.svh"
module osdpa_core (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    // register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // character stream
    input  wire osdpa_pkg::osdpa_pix_t pix,
    // video outputs
    output logic                      pix_fg,
    output logic                      pix_fringe,
    output logic                      fast_blank,
    output logic                      video_mix_out,
    output logic                      contrast_reduce_out,
    // mode outputs
    output logic                      aspect_select,
    output logic                      char_coding_select,
    output logic [4:0]                row_count_max
);
    osdpa_pkg::osdpa_ctl_t shadow;
    osdpa_pkg::osdpa_ctl_t act;
    osdpa_pkg::osdpa_att_t att;
    osdpa_pkg::osdpa_att_t next_att;
    logic        grid_phase;

    // software writes land in the shadow copy
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            shadow <= '{default: `OSDPA_RST_REG};
        end else if (reg_wr) begin
            unique case (reg_addr)
                `OSDPA_A_FSCREEN: shadow.fscreen <= reg_wdata;
                `OSDPA_A_CHARSET: shadow.charset <= reg_wdata;
                `OSDPA_A_MODE0:   shadow.mode0   <= reg_wdata;
                `OSDPA_A_MODE1:   shadow.mode1   <= reg_wdata;
                default: ;
            endcase
        end
    end

    // copying only at line start keeps a line from changing style halfway
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            act <= '{default: `OSDPA_RST_REG};
        end else if (pix.line_start) begin
            act <= shadow;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `OSDPA_A_FSCREEN: reg_rdata <= shadow.fscreen;
                `OSDPA_A_CHARSET: reg_rdata <= shadow.charset;
                `OSDPA_A_MODE0:   reg_rdata <= shadow.mode0;
                `OSDPA_A_MODE1:   reg_rdata <= shadow.mode1;
                `OSDPA_A_STATUS:  reg_rdata <= {4'h_0000, att};
                default:          reg_rdata <= 8'h_0000;
            endcase
        end else begin
            reg_rdata <= 8'h_0000;
        end
    end

    // decoded global controls
    logic disp_on;
    logic wide80;
    logic parallel;
    logic toggle_ok;
    logic round_on;
    logic border_all;
    logic grid_on;
    assign disp_on    = act.mode0[`OSDPA_B_DISP_ON];
    assign wide80     = act.mode0[`OSDPA_B_WIDE80];
    // eighty columns forces serial coding
    assign parallel   = act.mode1[`OSDPA_B_CODING] & ~wide80;
    assign toggle_ok  = act.mode0[`OSDPA_B_BTOGGLE] & ~act.charset[`OSDPA_B_ALTSEL];
    assign round_on   = act.mode0[`OSDPA_B_ROUND] & ~wide80;
    assign border_all = act.mode0[`OSDPA_B_BALL];
    assign grid_on    = act.mode0[`OSDPA_B_GRID] & ~wide80;

    // cell attribute decode; the cell start slot already uses the new state
    logic is_ser;
    assign is_ser = pix.code < `OSDPA_SER_LIMIT;
    always_comb begin
        next_att = att;
        if (pix.line_start) begin
            next_att = '0;
        end
        if (pix.cell_start && pix.in_display) begin
            if (is_ser) begin
                next_att.under  = 1'b0;
                next_att.smooth = 1'b0;
                if (pix.code == `OSDPA_SER_FRINGE && toggle_ok) begin
                    next_att.fringe = ~next_att.fringe;
                end
                if (pix.code == `OSDPA_SER_CONCEAL) begin
                    next_att.conceal = 1'b1;
                end
                if (pix.code < `OSDPA_SER_ALPHA) begin
                    next_att.conceal = 1'b0;
                end
            end
            // attribute byte only exists in parallel coding
            if (parallel && pix.attr[`OSDPA_P_VALID]) begin
                next_att.under  = pix.attr[`OSDPA_P_UNDER];
                next_att.smooth = pix.attr[`OSDPA_P_SMOOTH];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            att <= '0;
        end else begin
            att <= next_att;
        end
    end

    // hardware mosaic: 2x3 sextants, rows 0-3, 4-6, 7-9
    logic       mosaic;
    logic [2:0] mos_idx;
    logic       mos_dot;
    always_comb begin
        mos_idx = 3'd4;
        if (pix.dot_row <= `OSDPA_MOS_R1) begin
            mos_idx = 3'd0;
        end else if (pix.dot_row <= `OSDPA_MOS_R2) begin
            mos_idx = 3'd2;
        end
        if (pix.dot_col > `OSDPA_MOS_C1) begin
            mos_idx = mos_idx + 3'd1;
        end
    end
    assign mosaic  = pix.code[7:6] == 2'b10;
    assign mos_dot = pix.code[mos_idx];

    // padded rows so that edge columns see blank neighbours
    logic [11:0] cur_p;
    logic [11:0] ver_p;
    logic        dot_on;
    logic        h_nb;
    logic        v_nb;
    logic        d_nb;
    assign cur_p  = {1'b0, pix.row_cur, 1'b0};
    // field picks the vertical neighbour: half-dot vertical resolution
    assign ver_p  = pix.field_odd ? {1'b0, pix.row_below, 1'b0}
                                  : {1'b0, pix.row_above, 1'b0};
    assign dot_on = is_ser ? 1'b0 : (mosaic ? mos_dot : cur_p[pix.dot_col + 4'd1]);
    assign h_nb   = pix.sub ? cur_p[pix.dot_col + 4'd2] : cur_p[pix.dot_col];
    assign v_nb   = ver_p[pix.dot_col + 4'd1];
    assign d_nb   = pix.sub ? ver_p[pix.dot_col + 4'd2] : ver_p[pix.dot_col];

    // mosaic shapes are blocks, rounding and fringe skip them
    logic shaped;
    logic round_add;
    logic fringe_on;
    logic fringe_add;
    logic under_add;
    assign shaped     = ~mosaic & ~is_ser & ~wide80;
    assign round_add  = round_on & shaped & ~dot_on & h_nb & v_nb
                      & (~d_nb | next_att.smooth);
    assign fringe_on  = (border_all | (toggle_ok & next_att.fringe)) & shaped;
    assign fringe_add = fringe_on & ~dot_on & (h_nb | v_nb);
    assign under_add  = next_att.under & (pix.dot_row == `OSDPA_DOT_LAST);

    logic hide;
    logic showing;
    logic full;
    logic fg;
    logic fr;
    logic bg;
    logic active;
    assign hide    = act.mode0[`OSDPA_B_CONCEAL] & next_att.conceal;
    assign showing = disp_on & pix.in_display;
    assign full    = disp_on & pix.in_fullscreen & ~pix.in_display;
    assign fg      = showing & ~hide & (dot_on | round_add | under_add);
    assign fr      = showing & ~hide & ~fg & fringe_add;
    assign bg      = (showing & ~fg & ~fr) | full;
    assign active  = showing | full;

    logic boxed;
    logic fb_level;
    // box mode limits contrast cut to the text box
    assign boxed    = ~act.fscreen[`OSDPA_B_BOXMODE] | pix.in_box;
    // grid toggle runs on half-dot slots, twice the dot rate
    assign fb_level = active & ~(grid_on & bg & grid_phase);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            grid_phase <= 1'b0;
        end else begin
            grid_phase <= ~grid_phase;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pix_fg     <= 1'b0;
            pix_fringe <= 1'b0;
        end else begin
            pix_fg     <= fg;
            pix_fringe <= fr;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            fast_blank          <= 1'b1;
            video_mix_out       <= 1'b0;
            contrast_reduce_out <= 1'b0;
        end else begin
            fast_blank          <= act.mode1[`OSDPA_B_FB_HIGH] ? fb_level : ~fb_level;
            video_mix_out       <= act.charset[`OSDPA_B_MIX_EN] & bg;
            contrast_reduce_out <= act.fscreen[`OSDPA_B_CCUT] & bg & boxed;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            aspect_select      <= 1'b0;
            char_coding_select <= 1'b0;
            row_count_max      <= `OSDPA_ROWS_PAGE;
        end else begin
            aspect_select      <= act.mode0[`OSDPA_B_ASPECT];
            char_coding_select <= parallel;
            row_count_max      <= act.mode1[`OSDPA_B_LINEMODE] ? `OSDPA_ROWS_LINE
                                                                 : `OSDPA_ROWS_PAGE;
        end
    end

    default clocking dc @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_write_mode0;
        reg_wr && reg_addr == `OSDPA_A_MODE0;
    endsequence

    chk_off_silent: assert property (!disp_on |=> !pix_fg && !video_mix_out)
        else $error("output active while display off");
    chk_fg_no_mix: assert property (pix_fg |-> !video_mix_out && !contrast_reduce_out)
        else $error("mix or half-tone during foreground");
    chk_mix_bg: assert property (act.charset[`OSDPA_B_MIX_EN] && bg |=> video_mix_out)
        else $error("translucency missing on background");
    // the copy taken at a line start in the write cycle itself still holds old shadow bits
    chk_delay_line: assert property (s_write_mode0 ##1 !pix.line_start
                                     |=> $stable(act.mode0))
        else $error("global bit applied before line start");
    chk_wide_noshape: assert property (wide80 |-> !round_add && !fringe_add)
        else $error("rounding or fringe in eighty columns");
    chk_under_last: assert property (showing && !hide && next_att.under
                                     && pix.dot_row == `OSDPA_DOT_LAST |=> pix_fg)
        else $error("underline line not foreground");
    chk_grid_toggle: assert property (grid_on && bg && $past(grid_on && bg)
                                      |=> fast_blank != $past(fast_blank))
        else $error("fast blank not toggling in grid mode");
    chk_fb_polar: assert property (act.mode1[`OSDPA_B_FB_HIGH] && fg |=> fast_blank)
        else $error("fast blank level wrong for polarity");
    chk_ser_clear: assert property (pix.cell_start && pix.in_display && is_ser
                                    |=> !att.under && !att.smooth)
        else $error("parallel attribute survived serial code");
    chk_box_cut: assert property (act.fscreen[`OSDPA_B_BOXMODE] && !pix.in_box
                                  |=> !contrast_reduce_out)
        else $error("half-tone outside box in box mode");
    chk_round_fg: assert property (showing && !hide && round_add |=> pix_fg)
        else $error("rounding half-dot not foreground");
    chk_fringe_excl: assert property (pix_fringe |-> !pix_fg)
        else $error("fringe and foreground together");
    chk_wide_serial: assert property (wide80 |=> !char_coding_select)
        else $error("parallel coding in eighty columns");
endmodule : osdpa_core
`default_nettype wire

// ---- core/osdpa_map.svh ----
// offsets, field positions, reset values and fixed counts of the osd pixel attribute block
`ifndef OSDPA_MAP_SVH
`define OSDPA_MAP_SVH
`define OSDPA_A_FSCREEN    8'h_00F3
`define OSDPA_A_CHARSET    8'h_00F5
`define OSDPA_A_MODE0      8'h_00FA
`define OSDPA_A_MODE1      8'h_00FB
`define OSDPA_A_STATUS     8'h_00FC
`define OSDPA_RST_REG      8'h_0000
// mode0 fields
`define OSDPA_B_DISP_ON    0
`define OSDPA_B_ASPECT     1
`define OSDPA_B_CONCEAL    2
`define OSDPA_B_BTOGGLE    3
`define OSDPA_B_BALL       4
`define OSDPA_B_ROUND      5
`define OSDPA_B_GRID       6
`define OSDPA_B_WIDE80     7
// mode1 fields
`define OSDPA_B_FB_HIGH    0
`define OSDPA_B_CODING     1
`define OSDPA_B_LINEMODE   2
// charset and full screen fields
`define OSDPA_B_ALTSEL     7
`define OSDPA_B_MIX_EN     6
`define OSDPA_B_BOXMODE    7
`define OSDPA_B_CCUT       6
// character geometry and codes
`define OSDPA_DOT_LAST     4'h_0009
`define OSDPA_MOS_R1       4'h_0003
`define OSDPA_MOS_R2       4'h_0006
`define OSDPA_MOS_C1       4'h_0004
`define OSDPA_SER_LIMIT    8'h_0020
`define OSDPA_SER_FRINGE   8'h_001B
`define OSDPA_SER_CONCEAL  8'h_0018
`define OSDPA_SER_ALPHA    8'h_0008
`define OSDPA_P_UNDER      0
`define OSDPA_P_SMOOTH     1
`define OSDPA_P_VALID      7
`define OSDPA_ROWS_PAGE    5'h_0017
`define OSDPA_ROWS_LINE    5'h_000C
`endif

// ---- core/osdpa_pkg.sv ----
// types shared by the osd pixel attribute block
package osdpa_pkg;
    // one half-dot slot of the character stream
    typedef struct packed {
        logic       line_start;
        logic       cell_start;
        logic       in_display;
        logic       in_fullscreen;
        logic       in_box;
        logic       field_odd;
        logic       sub;
        logic [7:0] code;
        logic [7:0] attr;
        logic [3:0] dot_col;
        logic [3:0] dot_row;
        logic [9:0] row_above;
        logic [9:0] row_cur;
        logic [9:0] row_below;
    } osdpa_pix_t;

    // global attribute registers as written by software
    typedef struct packed {
        logic [7:0] fscreen;
        logic [7:0] charset;
        logic [7:0] mode0;
        logic [7:0] mode1;
    } osdpa_ctl_t;

    // line-local serial and parallel attribute state
    typedef struct packed {
        logic under;
        logic smooth;
        logic fringe;
        logic conceal;
    } osdpa_att_t;
endpackage : osdpa_pkg

// ---- verif/osdpa_vproc_model.sv ----
// model of the downstream video processor that mixes osd rgb with the picture
`timescale 1ns/100ps
`default_nettype none
module osdpa_vproc_model (
    // clock
    input  wire logic mclk,
    // osd control lines
    input  wire logic fast_blank,
    input  wire logic video_mix_out,
    input  wire logic contrast_reduce_out,
    input  wire logic fb_high,
    // slot counts seen by the mixer
    output int        osd_slots,
    output int        mix_slots
);
    initial begin
        osd_slots = 0;
        mix_slots = 0;
    end
    // the switch follows the programmed level, so a polarity slip shows as a count error
    always @(posedge mclk) begin
        if (fast_blank === fb_high) begin
            osd_slots++;
        end
        if (video_mix_out === 1'b1 || contrast_reduce_out === 1'b1) begin
            mix_slots++;
        end
    end
endmodule : osdpa_vproc_model
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench of the osd pixel attribute block
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic                  mclk;
    logic                  sys_rst;
    logic [7:0]            reg_addr;
    logic [7:0]            reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [7:0]            reg_rdata;
    osdpa_pkg::osdpa_pix_t p;
    logic                  pix_fg;
    logic                  pix_fringe;
    logic                  fast_blank;
    logic                  video_mix_out;
    logic                  contrast_reduce_out;
    logic                  aspect_select;
    logic                  char_coding_select;
    logic [4:0]            row_count_max;
    logic                  fb_high;
    int                    fails;
    int                    comparisons;
    int                    osd_slots;
    int                    mix_slots;

    osdpa_core u_dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pix(p), .pix_fg(pix_fg), .pix_fringe(pix_fringe), .fast_blank(fast_blank),
        .video_mix_out(video_mix_out), .contrast_reduce_out(contrast_reduce_out),
        .aspect_select(aspect_select), .char_coding_select(char_coding_select),
        .row_count_max(row_count_max));
    osdpa_vproc_model u_vproc (.mclk(mclk), .fast_blank(fast_blank),
        .video_mix_out(video_mix_out), .contrast_reduce_out(contrast_reduce_out),
        .fb_high(fb_high), .osd_slots(osd_slots), .mix_slots(mix_slots));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        fb_high   <= (a == 8'h_00FB) ? d[0] : fb_high;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk(what, exp, reg_rdata);
    endtask : rd

    // one slot at dot column 0, judged just after the clock edge that samples it
    task automatic slot(input logic ls, input logic [7:0] code, input logic [7:0] attr,
                        input logic [9:0] cur, input logic [3:0] row);
        @(posedge mclk);
        p.line_start <= ls;
        p.cell_start <= ~ls;
        p.code       <= code;
        p.attr       <= attr;
        p.row_cur    <= cur;
        p.dot_row    <= row;
        @(posedge mclk);
        p.line_start <= 1'b0;
        p.cell_start <= 1'b0;
        #1;
    endtask : slot

    task automatic t_reset;
        rd(8'h_00FA, 8'h_0000, "mode0");
        rd(8'h_00FB, 8'h_0000, "mode1");
        rd(8'h_0010, 8'h_0000, "unmapped");
        chk("aspect", 8'h_0000, {7'h_0000, aspect_select});
        chk("coding", 8'h_0000, {7'h_0000, char_coding_select});
        chk("rows", 8'h_0017, {3'h_0, row_count_max});
        chk("fblank", 8'h_0001, {7'h_0000, fast_blank});
        $display("test reset done");
    endtask : t_reset

    task automatic t_modes;
        wr(8'h_00FA, 8'h_0002);
        wr(8'h_00FB, 8'h_0006);
        rd(8'h_00FA, 8'h_0002, "mode0 back");
        chk("aspect held", 8'h_0000, {7'h_0000, aspect_select});
        slot(1'b1, 8'h_0000, 8'h_0000, 10'h_000, 4'h_0);
        // mode outputs follow the copy one clock after it is loaded
        @(posedge mclk);
        #1;
        chk("aspect", 8'h_0001, {7'h_0000, aspect_select});
        chk("coding", 8'h_0001, {7'h_0000, char_coding_select});
        chk("rows", 8'h_000C, {3'h_0, row_count_max});
        wr(8'h_00FA, 8'h_0082);
        slot(1'b1, 8'h_0000, 8'h_0000, 10'h_000, 4'h_0);
        @(posedge mclk);
        #1;
        chk("coding 80", 8'h_0000, {7'h_0000, char_coding_select});
        $display("test modes done");
    endtask : t_modes

    task automatic t_pixels;
        wr(8'h_00F3, 8'h_0040);
        wr(8'h_00F5, 8'h_0040);
        wr(8'h_00FA, 8'h_0001);
        wr(8'h_00FB, 8'h_0000);
        slot(1'b1, 8'h_0000, 8'h_0000, 10'h_000, 4'h_0);
        slot(1'b0, 8'h_0041, 8'h_0000, 10'h_001, 4'h_0);
        chk("fg", 8'h_0001, {7'h_0000, pix_fg});
        chk("fblank fg", 8'h_0000, {7'h_0000, fast_blank});
        chk("tone fg", 8'h_0000, {video_mix_out, 6'h_00, contrast_reduce_out});
        slot(1'b0, 8'h_0041, 8'h_0000, 10'h_000, 4'h_0);
        chk("tone bg", 8'h_0081, {video_mix_out, 6'h_00, contrast_reduce_out});
        wr(8'h_00FB, 8'h_0001);
        slot(1'b1, 8'h_0000, 8'h_0000, 10'h_000, 4'h_0);
        slot(1'b0, 8'h_0041, 8'h_0000, 10'h_001, 4'h_0);
        chk("fblank high", 8'h_0001, {7'h_0000, fast_blank});
        wr(8'h_00FA, 8'h_0000);
        slot(1'b1, 8'h_0000, 8'h_0000, 10'h_000, 4'h_0);
        slot(1'b0, 8'h_0041, 8'h_0000, 10'h_000, 4'h_0);
        chk("tone off", 8'h_0000, {video_mix_out, 6'h_00, contrast_reduce_out});
        chk("mixer saw", 8'h_0001, {7'h_0000, mix_slots > 0});
        $display("test pixels done");
    endtask : t_pixels

    task automatic t_attr;
        wr(8'h_00FB, 8'h_0002);
        wr(8'h_00FA, 8'h_0011);
        slot(1'b1, 8'h_0000, 8'h_0000, 10'h_000, 4'h_0);
        slot(1'b0, 8'h_0041, 8'h_0081, 10'h_000, 4'h_9);
        chk("underline", 8'h_0001, {7'h_0000, pix_fg});
        slot(1'b0, 8'h_0041, 8'h_0000, 10'h_000, 4'h_9);
        chk("underline held", 8'h_0001, {7'h_0000, pix_fg});
        // right half-dot, so the lit column 1 is the horizontal neighbour
        @(posedge mclk);
        p.sub <= 1'b1;
        slot(1'b0, 8'h_0041, 8'h_0000, 10'h_002, 4'h_0);
        chk("fringe", 8'h_0010, {3'h_0, pix_fringe, 3'h_0, pix_fg});
        wr(8'h_00FA, 8'h_0091);
        slot(1'b1, 8'h_0000, 8'h_0000, 10'h_000, 4'h_0);
        slot(1'b0, 8'h_0041, 8'h_0000, 10'h_002, 4'h_0);
        chk("fringe 80", 8'h_0000, {7'h_0000, pix_fringe});
        @(posedge mclk);
        p.sub <= 1'b0;
        $display("test attributes done");
    endtask : t_attr

    task automatic t_shape;
        logic b0;
        wr(8'h_00F3, 8'h_00C0);
        wr(8'h_00FA, 8'h_0041);
        wr(8'h_00FB, 8'h_0000);
        slot(1'b1, 8'h_0000, 8'h_0000, 10'h_000, 4'h_0);
        slot(1'b0, 8'h_0041, 8'h_0000, 10'h_000, 4'h_0);
        chk("cut outside box", 8'h_0000, {7'h_0000, contrast_reduce_out});
        b0 = fast_blank;
        @(posedge mclk);
        p.in_box <= 1'b1;
        #1;
        chk("grid toggle", {7'h_0000, ~b0}, {7'h_0000, fast_blank});
        @(posedge mclk);
        p.in_box <= 1'b0;
        #1;
        chk("cut inside box", 8'h_0001, {7'h_0000, contrast_reduce_out});
        wr(8'h_00FA, 8'h_0021);
        @(posedge mclk);
        p.sub       <= 1'b1;
        p.row_above <= 10'h_001;
        slot(1'b1, 8'h_0000, 8'h_0000, 10'h_000, 4'h_0);
        slot(1'b0, 8'h_0041, 8'h_0000, 10'h_002, 4'h_0);
        chk("round", 8'h_0001, {7'h_0000, pix_fg});
        chk("osd slots", 8'h_0001, {7'h_0000, osd_slots > 0});
        @(posedge mclk);
        p.sub       <= 1'b0;
        p.row_above <= 10'h_000;
        $display("test shape done");
    endtask : t_shape

    task automatic t_conceal(input logic [7:0] m0, input logic [7:0] exp);
        wr(8'h_00FB, 8'h_0000);
        wr(8'h_00FA, m0);
        slot(1'b1, 8'h_0000, 8'h_0000, 10'h_000, 4'h_0);
        slot(1'b0, 8'h_0018, 8'h_0000, 10'h_000, 4'h_0);
        slot(1'b0, 8'h_0041, 8'h_0000, 10'h_001, 4'h_0);
        chk("conceal", exp, {7'h_0000, pix_fg});
        $display("test conceal done");
    endtask : t_conceal

    task automatic summarize;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    initial begin
        fails = 0;
        comparisons = 0;
        sys_rst = 1'b1;
        reg_addr = 8'h_0000;
        reg_wdata = 8'h_0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        fb_high = 1'b0;
        p = '0;
        p.in_display = 1'b1;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_modes();
        t_pixels();
        t_attr();
        t_shape();
        t_conceal(8'h_0005, 8'h_0000);
        t_conceal(8'h_0001, 8'h_0001);
        summarize();
    end

    // the tests need about 130 clocks; a hang is cut off well beyond that
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        summarize();
    end
endmodule : tb
`default_nettype wire
